/* File: core/pdots_top.sv */
// PDO transmission scheduler: one transmit and one receive object over APB
//
// How it works
// R01: Type 0 received data waits, without touching outputs, for next SYNC.
// R02: Type 0 transmit samples at SYNC, sends only if mapped data changed.
// R03: Types 1-240 transmit once every n SYNC messages, n being the type.
// R04: Received data of types 0-240 becomes valid at the following SYNC.
// R05: SYNC period supervised; on loss outputs go to the error value.
// R06: Type 252 samples at SYNC and sends only on a remote request.
// R07: Type 253 samples continuously and sends only on a remote request.
// R08: Type 254 sends on application event, 255 on any input change; here only a change of mapped input bytes sends.
// R09: Inhibit time spaces sends; first send after quiet goes at once.
// R10: Event timer expiry is an event and triggers a transmission.
// R11: An application event sends the object and restarts the event timer.
// R12: Receive watchdog flags the application when no frame arrives in time.
// R13: Mapping count registers give the number of entries that follow.
// R14: Configurer disables the object via identifier bit 31 before remap.
// R15: Count cleared, entries rewritten, count written and checked here.
// R16: Configurer re-enables the object by writing its identifier.
// R17: Dummy mapping entries cause received bytes to be ignored.
// R18: Input and output counts are readable in one register.
// R19: Default mapping places bytes in physical order.
// R20: Identifier register holds an 11-bit identifier, top bit disables.
// R21: Each object holds its transmission type in a register of its own.
// R22: Cyclic SYNC counter restarts after each transmit trigger.
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pdots_consts.svh"
module pdots_top #(
    parameter logic [6:0] NODE_ID = 7'h01,
    parameter int DIN_BYTES = 8,
    parameter int DOUT_BYTES = 8,
    parameter int AIN_COUNT = 0,
    parameter int AOUT_COUNT = 0,
    parameter int TICK_CYCLES = `PDOTS_TICK_NS / `PDOTS_CLK_NS,
    parameter logic [63:0] ERR_OUT = 64'h0
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // CAN controller side
    input wire logic sync_pulse,
    input wire pdots_pkg::pdots_can_rx_t can_rx,
    output var pdots_pkg::pdots_can_tx_t can_tx,
    input wire logic tx_ack,
    // Application side
    input wire logic [63:0] din,
    input wire logic app_event,
    output logic [63:0] dout,
    output logic out_error,
    output logic rx_timeout
);
    localparam logic [3:0] TX_CNT_RST = 4'(DIN_BYTES > 8 ? 8 : DIN_BYTES);
    localparam logic [3:0] RX_CNT_RST = 4'(DOUT_BYTES > 8 ? 8 : DOUT_BYTES);

    function automatic logic is_map(input logic [7:0] a, input logic [7:0] b);
        is_map = (a[7:5] == b[7:5]) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic map_ok(input logic [7:0][7:0] map,
                                    input logic [3:0] cnt,
                                    input logic [3:0] nbytes);
        map_ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < cnt && !map[i][`PDOTS_MAP_DUMMY_BIT] &&
                map[i][3:0] >= nbytes) begin
                map_ok = 1'b0;
            end
        end
    endfunction

    function automatic logic [63:0] tx_build(input logic [63:0] src,
                                             input logic [7:0][7:0] map,
                                             input logic [3:0] cnt);
        tx_build = 64'h0;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < cnt && !map[i][`PDOTS_MAP_DUMMY_BIT]) begin
                tx_build[i*8 +: 8] = src[map[i][2:0]*8 +: 8];
            end
        end
    endfunction

    function automatic logic [63:0] rx_apply(input logic [63:0] cur,
                                             input logic [63:0] frame,
                                             input logic [7:0][7:0] map,
                                             input logic [3:0] cnt);
        rx_apply = cur;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < cnt && !map[i][`PDOTS_MAP_DUMMY_BIT]) begin
                rx_apply[map[i][2:0]*8 +: 8] = frame[i*8 +: 8];
            end
        end
    endfunction

    logic [15:0] pre_reg;
    logic [63:0] din_s1_reg, din_s2_reg;
    logic tx_off_reg, rx_off_reg;
    logic [10:0] tx_id_reg, rx_id_reg;
    logic [7:0] tx_type_reg, rx_type_reg, sync_cnt_reg;
    logic [15:0] tx_inh_reg, tx_evt_reg, rx_wdog_reg, sync_per_reg;
    logic [3:0] tx_cnt_reg, rx_cnt_reg;
    logic [7:0][7:0] tx_map_reg, rx_map_reg;
    logic sync_lost_reg, rx_to_reg, tx_maperr_reg, rx_maperr_reg;
    logic rx_pend_reg, pend_reg, pready_reg, pslverr_reg;
    logic [63:0] rx_buf_reg, sample_reg, last_frame_reg, dout_reg;
    logic [31:0] prdata_reg;
    pdots_pkg::pdots_can_tx_t can_tx_reg;
    pdots_pkg::pdots_tx_state_t state_reg, state_next;
    logic inh_ok, evt_fire, wd_fire, sync_fire;

    // Time base: one tick per inhibit/timer unit
    wire tick = (pre_reg == 16'(TICK_CYCLES - 1));

    // APB decode
    wire setup = psel && !penable;
    wire commit = psel && penable && pready_reg;
    wire do_wr = commit && pwrite && !pslverr_reg;
    wire [2:0] a_idx = paddr[4:2];
    wire h_txcob = (paddr == `PDOTS_OFS_TX_COBID);
    wire h_txtyp = (paddr == `PDOTS_OFS_TX_TYPE);
    wire h_txinh = (paddr == `PDOTS_OFS_TX_INHIBIT);
    wire h_txevt = (paddr == `PDOTS_OFS_TX_EVTMR);
    wire h_rxcob = (paddr == `PDOTS_OFS_RX_COBID);
    wire h_rxtyp = (paddr == `PDOTS_OFS_RX_TYPE);
    wire h_rxwd = (paddr == `PDOTS_OFS_RX_WDOG);
    wire h_syncp = (paddr == `PDOTS_OFS_SYNC_PERIOD);
    wire h_txcnt = (paddr == `PDOTS_OFS_TX_MAPCNT);
    wire h_rxcnt = (paddr == `PDOTS_OFS_RX_MAPCNT);
    wire h_stat = (paddr == `PDOTS_OFS_STATUS);
    wire h_io = (paddr == `PDOTS_OFS_IO_COUNT);
    wire h_rxmap = is_map(paddr, `PDOTS_OFS_RX_MAP);
    wire h_txmap = is_map(paddr, `PDOTS_OFS_TX_MAP);
    wire hit = h_txcob || h_txtyp || h_txinh || h_txevt || h_rxcob ||
        h_rxtyp || h_rxwd || h_syncp || h_txcnt || h_rxcnt || h_stat ||
        h_io || h_rxmap || h_txmap;

    // Remap sequence checks: count only while disabled, entries at count 0
    wire tx_map_ok = map_ok(tx_map_reg, pwdata[3:0], 4'(DIN_BYTES));
    wire rx_map_ok = map_ok(rx_map_reg, pwdata[3:0], 4'(DOUT_BYTES));
    wire cnt_range_bad = (pwdata[31:4] != 28'h0) ||
        (pwdata[3:0] > `PDOTS_MAP_MAX);
    wire txcnt_bad = h_txcnt && (!tx_off_reg || cnt_range_bad || !tx_map_ok);
    wire rxcnt_bad = h_rxcnt && (!rx_off_reg || cnt_range_bad || !rx_map_ok);
    wire map_bad = (h_txmap && tx_cnt_reg != 4'h0) ||
        (h_rxmap && rx_cnt_reg != 4'h0);
    wire type_rsvd = pwdata[7:0] > `PDOTS_TYPE_CYC_MAX &&
        pwdata[7:0] < `PDOTS_TYPE_RTR_SYNC;
    wire type_bad = (h_txtyp || h_rxtyp) && type_rsvd;
    wire wr_bad = txcnt_bad || rxcnt_bad || map_bad || type_bad || h_io;
    wire acc_bad = !hit || (pwrite && wr_bad);

    wire [31:0] st_word = {27'h0, rx_pend_reg, rx_maperr_reg, tx_maperr_reg,
        rx_to_reg, sync_lost_reg};
    wire [31:0] io_word = {8'(AOUT_COUNT), 8'(AIN_COUNT), 8'(DOUT_BYTES),
        8'(DIN_BYTES)}; // [R18]
    wire [31:0] rd_val =
        h_txcob ? {tx_off_reg, 20'h0, tx_id_reg} : // [R20]
        h_txtyp ? {24'h0, tx_type_reg} : // [R21]
        h_txinh ? {16'h0, tx_inh_reg} :
        h_txevt ? {16'h0, tx_evt_reg} :
        h_rxcob ? {rx_off_reg, 20'h0, rx_id_reg} :
        h_rxtyp ? {24'h0, rx_type_reg} :
        h_rxwd ? {16'h0, rx_wdog_reg} :
        h_syncp ? {16'h0, sync_per_reg} :
        h_txcnt ? {28'h0, tx_cnt_reg} : // [R13]
        h_rxcnt ? {28'h0, rx_cnt_reg} :
        h_stat ? st_word :
        h_io ? io_word :
        h_rxmap ? {24'h0, rx_map_reg[a_idx]} :
        h_txmap ? {24'h0, tx_map_reg[a_idx]} : 32'h0;

    // Receive object
    wire rx_hit = can_rx.valid && !can_rx.rtr && !rx_off_reg &&
        (can_rx.id == rx_id_reg);
    wire rx_sync_type = (rx_type_reg <= `PDOTS_TYPE_CYC_MAX);
    wire apply_sync = sync_pulse && rx_pend_reg; // [R01] [R04]
    wire apply_now = rx_hit && !rx_sync_type;
    wire [63:0] dout_next = sync_lost_reg ? ERR_OUT : // [R05]
        apply_sync ? rx_apply(dout_reg, rx_buf_reg, rx_map_reg, rx_cnt_reg) :
        apply_now ? rx_apply(dout_reg, can_rx.data, rx_map_reg, rx_cnt_reg) :
        dout_reg; // [R17]

    // Transmit object
    wire launch = (state_reg == pdots_pkg::PDOTS_TX_IDLE) && pend_reg &&
        inh_ok && !tx_off_reg; // [R09]
    wire tx_t0 = (tx_type_reg == `PDOTS_TYPE_ACYC);
    wire rx_type_bad_tx = (tx_type_reg > `PDOTS_TYPE_CYC_MAX);
    wire tx_cyc = (tx_type_reg >= `PDOTS_TYPE_CYC_MIN) && !rx_type_bad_tx;
    wire tx_r252 = (tx_type_reg == `PDOTS_TYPE_RTR_SYNC);
    wire tx_r253 = (tx_type_reg == `PDOTS_TYPE_RTR_ASYNC);
    wire tx_254 = (tx_type_reg == `PDOTS_TYPE_VENDOR);
    wire tx_255 = (tx_type_reg == `PDOTS_TYPE_PROFILE);
    wire tx_async = tx_254 || tx_255;
    wire sync_sampled = tx_t0 || tx_cyc || tx_r252;
    wire [63:0] frame_live = tx_build(din_s2_reg, tx_map_reg, tx_cnt_reg);
    wire [63:0] frame_samp = tx_build(sample_reg, tx_map_reg, tx_cnt_reg);
    wire [63:0] frame_now = sync_sampled ? frame_samp : frame_live;
    wire cyc_due = ((sync_cnt_reg + 8'h01) >= tx_type_reg);
    wire trig_t0 = sync_pulse && tx_t0 && (frame_live != last_frame_reg);
    wire trig_cyc = sync_pulse && tx_cyc && cyc_due; // [R03]
    wire rtr_req = can_rx.valid && can_rx.rtr && (can_rx.id == tx_id_reg);
    wire trig_rtr = rtr_req && (tx_r252 || tx_r253); // [R06] [R07]
    // A change seen in the launch cycle already rides in the launched frame
    wire trig_chg = tx_255 && !launch &&
        (frame_live != last_frame_reg); // [R08]
    wire trig_app = tx_254 && app_event; // [R08]
    wire trig_evt = tx_async && evt_fire; // [R10]
    wire trig_any = !tx_off_reg && (trig_t0 || trig_cyc || trig_rtr ||
        trig_chg || trig_app || trig_evt); // [R02]

    always_comb begin
        case (state_reg)
            pdots_pkg::PDOTS_TX_IDLE: begin
                state_next = launch ? pdots_pkg::PDOTS_TX_BUSY : state_reg;
            end
            pdots_pkg::PDOTS_TX_BUSY: begin
                state_next = tx_ack ? pdots_pkg::PDOTS_TX_IDLE : state_reg;
            end
            default: begin
                state_next = pdots_pkg::PDOTS_TX_IDLE;
            end
        endcase
    end

    // Restarting on send also covers an event inside a running period
    pdots_timer #(.W(16)) u_inhibit (.pclk(pclk), .presetn(presetn),
        .tick(tick), .restart(launch), .limit(tx_inh_reg),
        .elapsed(inh_ok), .fire()); // [R09]
    pdots_timer #(.W(16)) u_event (.pclk(pclk), .presetn(presetn),
        .tick(tick), .restart(launch || (do_wr && h_txevt)),
        .limit(tx_evt_reg), .elapsed(), .fire(evt_fire)); // [R11]
    pdots_timer #(.W(16)) u_wdog (.pclk(pclk), .presetn(presetn),
        .tick(tick), .restart(rx_hit), .limit(rx_wdog_reg),
        .elapsed(), .fire(wd_fire)); // [R12]
    pdots_timer #(.W(16)) u_syncmon (.pclk(pclk), .presetn(presetn),
        .tick(tick), .restart(sync_pulse), .limit(sync_per_reg),
        .elapsed(), .fire(sync_fire)); // [R05]

    // Default mapping: entry i carries byte i
    for (genvar g = 0; g < 8; g++) begin : g_map
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                tx_map_reg[g] <= 8'(g); // [R19]
                rx_map_reg[g] <= 8'(g);
            end else if (do_wr && a_idx == 3'(g)) begin
                if (h_txmap) tx_map_reg[g] <= pwdata[7:0];
                if (h_rxmap) rx_map_reg[g] <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 16'h0;
            din_s1_reg <= 64'h0;
            din_s2_reg <= 64'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pre_reg <= tick ? 16'h0 : pre_reg + 16'h1;
            din_s1_reg <= din;
            din_s2_reg <= din_s1_reg;
            pready_reg <= setup || (pready_reg && !commit);
            if (setup) begin
                pslverr_reg <= acc_bad;
                prdata_reg <= pwrite ? 32'h0 : rd_val;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_off_reg <= 1'b0;
            rx_off_reg <= 1'b0;
            tx_id_reg <= `PDOTS_TX_COBID_BASE + 11'(NODE_ID);
            rx_id_reg <= `PDOTS_RX_COBID_BASE + 11'(NODE_ID);
            tx_type_reg <= `PDOTS_TYPE_PROFILE;
            rx_type_reg <= `PDOTS_TYPE_PROFILE;
            tx_inh_reg <= 16'h0;
            tx_evt_reg <= 16'h0;
            rx_wdog_reg <= 16'h0;
            sync_per_reg <= 16'h0;
            tx_cnt_reg <= TX_CNT_RST;
            rx_cnt_reg <= RX_CNT_RST;
        end else if (do_wr) begin
            if (h_txcob) tx_off_reg <= pwdata[`PDOTS_COBID_OFF_BIT]; // [R20]
            if (h_txcob) tx_id_reg <= pwdata[`PDOTS_ID_W-1:0];
            if (h_rxcob) rx_off_reg <= pwdata[`PDOTS_COBID_OFF_BIT];
            if (h_rxcob) rx_id_reg <= pwdata[`PDOTS_ID_W-1:0];
            if (h_txtyp) tx_type_reg <= pwdata[7:0]; // [R21]
            if (h_rxtyp) rx_type_reg <= pwdata[7:0];
            if (h_txinh) tx_inh_reg <= pwdata[15:0];
            if (h_txevt) tx_evt_reg <= pwdata[15:0];
            if (h_rxwd) rx_wdog_reg <= pwdata[15:0];
            if (h_syncp) sync_per_reg <= pwdata[15:0];
            if (h_txcnt) tx_cnt_reg <= pwdata[3:0]; // [R15]
            if (h_rxcnt) rx_cnt_reg <= pwdata[3:0];
        end
    end

    // Sticky flags: a hardware set wins over a write-one clear
    wire clr = do_wr && h_stat;
    wire bad_cnt_wr = commit && pwrite && pslverr_reg && !cnt_range_bad;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_lost_reg <= 1'b0;
            rx_to_reg <= 1'b0;
            tx_maperr_reg <= 1'b0;
            rx_maperr_reg <= 1'b0;
        end else begin
            sync_lost_reg <= sync_fire ||
                (sync_lost_reg && !(clr && pwdata[`PDOTS_ST_SYNC_LOST]));
            rx_to_reg <= wd_fire ||
                (rx_to_reg && !(clr && pwdata[`PDOTS_ST_RX_TIMEOUT]));
            tx_maperr_reg <= (bad_cnt_wr && h_txcnt && !tx_map_ok) ||
                (tx_maperr_reg && !(clr && pwdata[`PDOTS_ST_TX_MAPERR]));
            rx_maperr_reg <= (bad_cnt_wr && h_rxcnt && !rx_map_ok) ||
                (rx_maperr_reg && !(clr && pwdata[`PDOTS_ST_RX_MAPERR]));
        end
    end

    // Process data path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf_reg <= 64'h0;
            rx_pend_reg <= 1'b0;
            dout_reg <= 64'h0;
            sample_reg <= 64'h0;
            last_frame_reg <= 64'h0;
            sync_cnt_reg <= 8'h0;
            pend_reg <= 1'b0;
            state_reg <= pdots_pkg::PDOTS_TX_IDLE;
            can_tx_reg <= '0;
        end else begin
            if (rx_hit && rx_sync_type) rx_buf_reg <= can_rx.data; // [R01]
            rx_pend_reg <= (rx_hit && rx_sync_type) ||
                (rx_pend_reg && !sync_pulse); // [R04]
            dout_reg <= dout_next;
            if (sync_pulse && sync_sampled) sample_reg <= din_s2_reg;
            if (do_wr && h_txtyp) begin
                sync_cnt_reg <= 8'h0;
            end else if (sync_pulse && tx_cyc) begin
                sync_cnt_reg <= cyc_due ? 8'h0 : sync_cnt_reg + 8'h1; // [R22]
            end
            pend_reg <= trig_any || (pend_reg && !launch);
            state_reg <= state_next;
            if (launch) begin
                can_tx_reg.req <= 1'b1;
                can_tx_reg.id <= tx_id_reg;
                can_tx_reg.data <= frame_now;
                last_frame_reg <= frame_now;
            end else if (tx_ack) begin
                can_tx_reg.req <= 1'b0;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign can_tx = can_tx_reg;
    assign dout = dout_reg;
    assign out_error = sync_lost_reg;
    assign rx_timeout = rx_to_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    rx_hold_a: assert property (rx_sync_type && !sync_pulse && // [R01]
        !sync_lost_reg |=> $stable(dout_reg))
        else $error("synchronous receive data changed outputs early");
    rx_apply_a: assert property (sync_pulse && rx_pend_reg && // [R04]
        !rx_hit |=> !rx_pend_reg)
        else $error("pending receive data not taken at SYNC");
    cyc_count_a: assert property (sync_pulse && tx_cyc && !tx_off_reg && // [R03]
        cyc_due |=> pend_reg && sync_cnt_reg == 8'h0)
        else $error("cyclic transmit not requested on nth SYNC");
    t0_quiet_a: assert property (tx_t0 && !pend_reg && // [R02]
        !(sync_pulse && frame_live != last_frame_reg) |=> !pend_reg)
        else $error("type 0 transmit without change at SYNC");
    rtr_only_a: assert property ((tx_r252 || tx_r253) && !pend_reg && // [R06]
        !rtr_req |=> !pend_reg)
        else $error("remote-only object sent without request");
    inhibit_gap_a: assert property (launch && tx_inh_reg != 16'h0 // [R09]
        |=> !inh_ok ##1 !launch)
        else $error("inhibit time not enforced after send");
    evt_restart_a: assert property (launch && tx_evt_reg > 16'h1 // [R11]
        |=> !evt_fire [*2])
        else $error("event timer not restarted by send");
    wdog_flag_a: assert property (wd_fire |=> rx_to_reg [*2]) // [R12]
        else $error("receive watchdog expiry not flagged");
    sync_err_a: assert property (sync_lost_reg |=> // [R05]
        dout_reg == ERR_OUT && out_error)
        else $error("outputs not in error state after SYNC loss");
endmodule
`default_nettype wire

/* File: common/pdots_consts.svh */
// Register offsets, field positions, reset values and timing constants
`ifndef PDOTS_CONSTS_SVH
`define PDOTS_CONSTS_SVH

`define PDOTS_OFS_TX_COBID 8'h00
`define PDOTS_OFS_TX_TYPE 8'h04
`define PDOTS_OFS_TX_INHIBIT 8'h08
`define PDOTS_OFS_TX_EVTMR 8'h0c
`define PDOTS_OFS_RX_COBID 8'h10
`define PDOTS_OFS_RX_TYPE 8'h14
`define PDOTS_OFS_RX_WDOG 8'h18
`define PDOTS_OFS_SYNC_PERIOD 8'h1c
`define PDOTS_OFS_TX_MAPCNT 8'h20
`define PDOTS_OFS_RX_MAPCNT 8'h24
`define PDOTS_OFS_STATUS 8'h28
`define PDOTS_OFS_IO_COUNT 8'h2c
`define PDOTS_OFS_RX_MAP 8'h40
`define PDOTS_OFS_TX_MAP 8'h60

`define PDOTS_COBID_OFF_BIT 31
`define PDOTS_ID_W 11
`define PDOTS_TX_COBID_BASE 11'h180
`define PDOTS_RX_COBID_BASE 11'h200

`define PDOTS_TYPE_ACYC 8'h00
`define PDOTS_TYPE_CYC_MIN 8'h01
`define PDOTS_TYPE_CYC_MAX 8'hf0
`define PDOTS_TYPE_RTR_SYNC 8'hfc
`define PDOTS_TYPE_RTR_ASYNC 8'hfd
`define PDOTS_TYPE_VENDOR 8'hfe
`define PDOTS_TYPE_PROFILE 8'hff

`define PDOTS_MAP_MAX 4'h8
`define PDOTS_MAP_DUMMY_BIT 7

`define PDOTS_ST_SYNC_LOST 0
`define PDOTS_ST_RX_TIMEOUT 1
`define PDOTS_ST_TX_MAPERR 2
`define PDOTS_ST_RX_MAPERR 3
`define PDOTS_ST_RX_PEND 4

`define PDOTS_TICK_NS 100000
`define PDOTS_CLK_NS 10

`endif

/* File: common/pdots_pkg.sv */
// Types shared by the scheduler: CAN frame carriers and transmit states
`include "pdots_consts.svh"
package pdots_pkg;
    typedef struct packed {
        logic valid;
        logic rtr;
        logic [`PDOTS_ID_W-1:0] id;
        logic [63:0] data;
    } pdots_can_rx_t;

    typedef struct packed {
        logic req;
        logic [`PDOTS_ID_W-1:0] id;
        logic [63:0] data;
    } pdots_can_tx_t;

    typedef enum logic [0:0] {
        PDOTS_TX_IDLE = 1'b0,
        PDOTS_TX_BUSY = 1'b1
    } pdots_tx_state_t;
endpackage

/* File: core/pdots_timer.sv */
// Tick counter used for inhibit, event timer, watchdog and SYNC supervision
`timescale 1ns/1ps
`default_nettype none
module pdots_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic tick,
    input wire logic restart,
    input wire logic [W-1:0] limit,
    // Status
    output logic elapsed,
    output logic fire
);
    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    logic [W-1:0] count_inc;
    logic fire_reg;
    logic fire_next;
    logic at_limit;

    // Starts saturated, so nothing fires before the first restart
    assign at_limit = (count_reg >= limit);
    assign count_inc = count_reg + 1'b1;
    assign count_next = restart ? '0 :
        ((tick && !at_limit) ? count_inc : count_reg);
    assign fire_next = tick && !restart && !at_limit &&
        (limit != '0) && (count_inc == limit);
    // A zero limit means the timer is off and never holds anything back
    assign elapsed = (limit == '0) || at_limit;
    assign fire = fire_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '1;
            fire_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            fire_reg <= fire_next;
        end
    end
endmodule
`default_nettype wire

/* File: verification/pdots_can_model.sv */
// CAN controller model: acknowledges each queued transmit frame after a delay
`timescale 1ns/1ps
`default_nettype none
module pdots_can_model #(
    parameter int DLY = 3
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Transmit request from the scheduler
    input wire pdots_pkg::pdots_can_tx_t can_tx,
    output logic tx_ack,
    // Record of frames taken
    output var int sent,
    output logic [63:0] last
);
    int wait_reg;
    // Count restarts on ack so a request held one more cycle is not taken twice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ack <= 1'b0;
            wait_reg <= 0;
            sent <= 0;
            last <= 64'h0;
        end else if (tx_ack) begin
            tx_ack <= 1'b0;
            wait_reg <= 0;
        end else if (can_tx.req) begin
            wait_reg <= wait_reg + 1;
            if (wait_reg == DLY - 1) begin
                tx_ack <= 1'b1;
                sent <= sent + 1;
                last <= can_tx.data;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/pdo_transmission_scheduler_bench.sv */
// Testbench for the PDO scheduler: registers, transmit types and receive path
`timescale 1ns/1ps
`default_nettype none
module pdo_transmission_scheduler_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, sync_pulse = 0, tx_ack, app_event = 0;
    logic out_error, rx_timeout;
    logic [63:0] din = 64'h0, dout, last;
    pdots_pkg::pdots_can_rx_t can_rx = '0;
    pdots_pkg::pdots_can_tx_t can_tx;
    int sent, err_count = 0, tests_run = 0, s;
    always #5 pclk = ~pclk;
    pdots_top #(.TICK_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sync_pulse(sync_pulse), .can_rx(can_rx),
        .can_tx(can_tx), .tx_ack(tx_ack), .din(din), .app_event(app_event),
        .dout(dout), .out_error(out_error), .rx_timeout(rx_timeout));
    pdots_can_model #(.DLY(3)) far (.pclk(pclk), .presetn(presetn),
        .can_tx(can_tx), .tx_ack(tx_ack), .sent(sent), .last(last));
    task chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Reads compare prdata with d; every access compares pslverr with e
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        chk({63'h0, pslverr}, {63'h0, e});
        if (!w) chk({32'h0, prdata}, {32'h0, d});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task want(input int n, input int lim);
        for (int i = 0; i < lim && sent != n; i++) @(posedge pclk);
        chk(64'(sent), 64'(n));
    endtask
    task syncp;
        @(posedge pclk);
        sync_pulse <= 1'b1;
        @(posedge pclk);
        sync_pulse <= 1'b0;
    endtask
    // Released lines carry the inverse so stale data cannot pass
    task frame(input logic r, input logic [10:0] id, input logic [63:0] d);
        @(posedge pclk);
        can_rx <= {1'b1, r, id, d};
        @(posedge pclk);
        can_rx <= {1'b0, 1'b0, ~id, ~d};
    endtask
    task results;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        results;
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h00, 32'h181, 0);
        apb(0, 8'h04, 32'hff, 0);
        apb(0, 8'h3c, 32'h0, 1);
        apb(1, 8'h04, 32'hf5, 1);
        apb(1, 8'h20, 32'h4, 1);
        apb(1, 8'h00, 32'h80000181, 0);
        apb(1, 8'h20, 32'h0, 0);
        apb(1, 8'h20, 32'h9, 1);
        apb(1, 8'h20, 32'h8, 0);
        apb(1, 8'h00, 32'h181, 0);
        din <= 64'h8877665544332211;
        want(1, 100);
        chk(last, 64'h8877665544332211);
        apb(1, 8'h08, 32'h5, 0);
        repeat (40) @(posedge pclk);
        din <= 64'h0123;
        want(2, 12);
        din <= 64'h4567;
        repeat (8) @(posedge pclk);
        chk(64'(sent), 64'd2);
        want(3, 100);
        chk(last, 64'h4567);
        apb(1, 8'h08, 32'h0, 0);
        apb(1, 8'h04, 32'h3, 0);
        s = sent;
        repeat (6) begin
            syncp;
            repeat (8) @(posedge pclk);
        end
        chk(64'(sent), 64'(s + 2));
        apb(1, 8'h04, 32'hfc, 0);
        din <= 64'haaaa;
        repeat (4) @(posedge pclk);
        syncp;
        din <= 64'hbbbb;
        repeat (20) @(posedge pclk);
        chk(64'(sent), 64'(s + 2));
        frame(1, 11'h181, 64'h0);
        want(s + 3, 20);
        chk(last, 64'haaaa);
        apb(1, 8'h04, 32'hfd, 0);
        frame(1, 11'h181, 64'h0);
        want(s + 4, 20);
        chk(last, 64'hbbbb);
        apb(1, 8'h04, 32'hfe, 0);
        apb(1, 8'h0c, 32'h3, 0);
        app_event <= 1'b1;
        @(posedge pclk);
        app_event <= 1'b0;
        want(s + 5, 12);
        want(s + 6, 40);
        apb(1, 8'h0c, 32'h0, 0);
        apb(1, 8'h14, 32'h0, 0);
        apb(1, 8'h18, 32'h2, 0);
        frame(0, 11'h201, 64'hfeedc0de12345678);
        repeat (6) @(posedge pclk);
        chk(dout, 64'h0);
        syncp;
        repeat (2) @(posedge pclk);
        chk(dout, 64'hfeedc0de12345678);
        repeat (30) @(posedge pclk);
        chk({63'h0, rx_timeout}, 64'h1);
        apb(1, 8'h1c, 32'h2, 0);
        repeat (20) @(posedge pclk);
        chk(dout, 64'h0);
        chk({63'h0, out_error}, 64'h1);
        apb(0, 8'h28, 32'h3, 0);
        apb(0, 8'h2c, 32'h808, 0);
        results;
    end
endmodule
`default_nettype wire
